// [rtl/vsg_map.svh]
`ifndef VSG_MAP_SVH
`define VSG_MAP_SVH

// ----------------------------------------------------------------------------
// register indices on the host load port
// ----------------------------------------------------------------------------
`define VSG_ADDR_STATUS    3'h0
`define VSG_ADDR_H_TOTAL   3'h1
`define VSG_ADDR_H_START   3'h2
`define VSG_ADDR_H_END     3'h3
`define VSG_ADDR_V_TOTAL   3'h4
`define VSG_ADDR_V_START   3'h5
`define VSG_ADDR_V_END     3'h6

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define VSG_CEN_BIT        10

// ----------------------------------------------------------------------------
// default values loaded by a clear pulse
// ----------------------------------------------------------------------------
`define VSG_RST_STATUS     12'h000
`define VSG_RST_H_TOTAL    12'h1FF
`define VSG_RST_H_START    12'h010
`define VSG_RST_H_END      12'h040
`define VSG_RST_V_TOTAL    12'h105
`define VSG_RST_V_START    12'h003
`define VSG_RST_V_END      12'h006

`endif

// [rtl/vsg_pkg.sv]
package vsg_pkg;

    // ------------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [11:0] total;
        logic [11:0] drv_start;
        logic [11:0] drv_end;
    } vsg_axis_t;

    typedef struct packed {
        logic [2:0]  addr;
        logic [11:0] data;
    } vsg_wr_t;

    typedef enum logic [0:0] {
        VSG_ST_FIRST = 1'b0,
        VSG_ST_RUN   = 1'b1
    } vsg_mode_t;

endpackage : vsg_pkg

// [rtl/vsg_drive.sv]
module vsg_drive #(
    parameter int CNT_W = 12
) (
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    input  wire logic             run,
    input  wire logic             first,
    input  wire logic [CNT_W-1:0] count,
    input  wire logic [CNT_W-1:0] drv_start,
    input  wire logic [CNT_W-1:0] drv_end,
    output logic                  drive
);

    logic drive_ff;
    logic nxt_drive;

    // ------------------------------------------------------------------------
    // drive window
    // ------------------------------------------------------------------------
    always_comb begin
        if (first) begin
            nxt_drive = (count < drv_end);
        end else begin
            nxt_drive = (count >= drv_start) && (count < drv_end);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            drive_ff <= 1'b0;
        end else if (run) begin
            drive_ff <= nxt_drive;
        end
    end

    assign drive = drive_ff;

    first_start_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        run && first && count == '0 && drv_end != '0 |=> drive)
        else $error("drive not started at first clock after restart");

    first_end_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        run && first && count >= drv_end |=> !drive)
        else $error("drive not ended at programmed end in first frame");

    normal_start_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        run && !first && count < drv_start |=> !drive)
        else $error("drive active before programmed start");

endmodule : vsg_drive

// [rtl/vsg_ctrl.sv]
`include "vsg_map.svh"
// Operation
// - clock-enable bit defaults to zero on load
// - clear loads defaults, disabled clock halts timing
// - restart keeps programmed timing registers
// - first frame drives start at first clock
// - first frame drives end as programmed
// - later frames use programmed start and end
// - lowered total lets counter run to wrap
// - restart restarts all counters from zero
module vsg_ctrl #(
    parameter int         CNT_W       = 12,
    parameter logic [0:0] CEN_DEFAULT = 1'b0
) (
    input  wire logic              sys_clk,
    input  wire logic              arst_n,
    input  wire logic              clear,
    input  wire logic              restart,
    input  wire logic              wr_en,
    input  wire vsg_pkg::vsg_wr_t  wr,
    output logic                   h_drive,
    output logic                   v_drive,
    output logic [CNT_W-1:0]       h_count,
    output logic [CNT_W-1:0]       v_count,
    output logic [11:0]            status,
    output logic                   first_frame
);

    // ------------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------------
    if (CNT_W != 12) begin : g_bad_width
        $error("vsg_ctrl: counters must match the 12-bit timing registers");
    end

    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    logic [11:0]        status_ff;
    vsg_pkg::vsg_axis_t h_cfg_ff;
    vsg_pkg::vsg_axis_t v_cfg_ff;
    logic [CNT_W-1:0]   h_cnt_ff;
    logic [CNT_W-1:0]   v_cnt_ff;
    logic [CNT_W-1:0]   nxt_h_cnt;
    logic [CNT_W-1:0]   nxt_v_cnt;
    vsg_pkg::vsg_mode_t mode_ff;
    logic               cen;
    logic               h_wrap;
    logic               v_wrap;
    logic               run;

    assign cen = status_ff[`VSG_CEN_BIT];
    // restart and clear themselves steer the counters, not the drives
    assign run = cen && !clear && !restart;

    // ------------------------------------------------------------------------
    // register loads
    // ------------------------------------------------------------------------
    // a restart touches no register, so it is absent here
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_ff          <= `VSG_RST_STATUS;
            h_cfg_ff.total     <= `VSG_RST_H_TOTAL;
            h_cfg_ff.drv_start <= `VSG_RST_H_START;
            h_cfg_ff.drv_end   <= `VSG_RST_H_END;
            v_cfg_ff.total     <= `VSG_RST_V_TOTAL;
            v_cfg_ff.drv_start <= `VSG_RST_V_START;
            v_cfg_ff.drv_end   <= `VSG_RST_V_END;
        end else if (clear) begin
            status_ff                <= `VSG_RST_STATUS;
            status_ff[`VSG_CEN_BIT]  <= CEN_DEFAULT;
            h_cfg_ff.total           <= `VSG_RST_H_TOTAL;
            h_cfg_ff.drv_start       <= `VSG_RST_H_START;
            h_cfg_ff.drv_end         <= `VSG_RST_H_END;
            v_cfg_ff.total           <= `VSG_RST_V_TOTAL;
            v_cfg_ff.drv_start       <= `VSG_RST_V_START;
            v_cfg_ff.drv_end         <= `VSG_RST_V_END;
        end else if (wr_en) begin
            case (wr.addr)
                `VSG_ADDR_STATUS:  status_ff          <= wr.data;
                `VSG_ADDR_H_TOTAL: h_cfg_ff.total     <= wr.data;
                `VSG_ADDR_H_START: h_cfg_ff.drv_start <= wr.data;
                `VSG_ADDR_H_END:   h_cfg_ff.drv_end   <= wr.data;
                `VSG_ADDR_V_TOTAL: v_cfg_ff.total     <= wr.data;
                `VSG_ADDR_V_START: v_cfg_ff.drv_start <= wr.data;
                `VSG_ADDR_V_END:   v_cfg_ff.drv_end   <= wr.data;
                default:           status_ff          <= status_ff;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // counters
    // ------------------------------------------------------------------------
    // a count already past a lowered total only wraps to zero at the natural rollover
    assign h_wrap = (h_cnt_ff == h_cfg_ff.total) || (h_cnt_ff == CNT_MAX);
    assign v_wrap = (v_cnt_ff == v_cfg_ff.total) || (v_cnt_ff == CNT_MAX);

    always_comb begin
        nxt_h_cnt = h_wrap ? '0 : h_cnt_ff + CNT_W'(1);
        nxt_v_cnt = v_cnt_ff;
        if (h_wrap) begin
            nxt_v_cnt = v_wrap ? '0 : v_cnt_ff + CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            h_cnt_ff <= '0;
            v_cnt_ff <= '0;
        end else if (clear || restart) begin
            h_cnt_ff <= '0;
            v_cnt_ff <= '0;
        end else if (cen) begin
            h_cnt_ff <= nxt_h_cnt;
            v_cnt_ff <= nxt_v_cnt;
        end
    end

    // ------------------------------------------------------------------------
    // first-frame tracking
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_ff <= vsg_pkg::VSG_ST_RUN;
        end else begin
            case (mode_ff)
                vsg_pkg::VSG_ST_FIRST: begin
                    if (clear) begin
                        mode_ff <= vsg_pkg::VSG_ST_RUN;
                    end else if (restart) begin
                        mode_ff <= vsg_pkg::VSG_ST_FIRST;
                    end else if (cen && h_wrap && v_wrap) begin
                        mode_ff <= vsg_pkg::VSG_ST_RUN;
                    end
                end
                vsg_pkg::VSG_ST_RUN: begin
                    if (restart && !clear) begin
                        mode_ff <= vsg_pkg::VSG_ST_FIRST;
                    end
                end
                default: mode_ff <= vsg_pkg::VSG_ST_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // drive generators
    // ------------------------------------------------------------------------
    vsg_drive #(
        .CNT_W     (CNT_W)
    ) u_h_drive (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .run       (run),
        .first     (mode_ff == vsg_pkg::VSG_ST_FIRST),
        .count     (h_cnt_ff),
        .drv_start (h_cfg_ff.drv_start),
        .drv_end   (h_cfg_ff.drv_end),
        .drive     (h_drive)
    );

    vsg_drive #(
        .CNT_W     (CNT_W)
    ) u_v_drive (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .run       (run),
        .first     (mode_ff == vsg_pkg::VSG_ST_FIRST),
        .count     (v_cnt_ff),
        .drv_start (v_cfg_ff.drv_start),
        .drv_end   (v_cfg_ff.drv_end),
        .drive     (v_drive)
    );

    assign h_count     = h_cnt_ff;
    assign v_count     = v_cnt_ff;
    assign status      = status_ff;
    assign first_frame = (mode_ff == vsg_pkg::VSG_ST_FIRST);

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    clear_default_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clear |=> status_ff[`VSG_CEN_BIT] == CEN_DEFAULT && h_cfg_ff.total == `VSG_RST_H_TOTAL)
        else $error("clear did not load default values");

    clear_halt_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clear ##1 (!cen && !restart && !wr_en)[*2] |-> h_cnt_ff == '0 && v_cnt_ff == '0)
        else $error("timing advanced after clear with clock disabled");

    restart_keep_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        restart && !clear && !wr_en |=> $stable(h_cfg_ff) && $stable(v_cfg_ff)
            && $stable(status_ff))
        else $error("restart altered a timing register");

    counter_overrun_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        run && h_cnt_ff > h_cfg_ff.total && h_cnt_ff != CNT_MAX
            |=> h_cnt_ff == $past(h_cnt_ff) + CNT_W'(1))
        else $error("overrun counter did not keep counting");

    restart_zero_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        restart && !clear |=> h_cnt_ff == '0 && v_cnt_ff == '0 && first_frame)
        else $error("restart did not restart counters");

    halt_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !cen && !clear && !restart |=> $stable(h_cnt_ff) && $stable(v_cnt_ff)
            && $stable(h_drive) && $stable(v_drive))
        else $error("timing moved while clock disabled");

    first_leave_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        first_frame && run && h_wrap && v_wrap |=> !first_frame)
        else $error("first frame did not end at frame completion");

endmodule : vsg_ctrl

// [dv/vsg_host.sv]
module vsg_host (
    input  wire logic        sys_clk,
    output logic             clear,
    output logic             restart,
    output logic             wr_en,
    output vsg_pkg::vsg_wr_t wr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        clear   = 1'b0;
        restart = 1'b0;
        wr_en   = 1'b0;
        wr      = '0;
    end

    // one request per call, then a quiet cycle; a released bus keeps the address and shows the inverse data
    task op(input logic c, input logic r, input logic w, input logic [2:0] a,
            input logic [11:0] d);
        @(negedge sys_clk);
        clear   = c;
        restart = r;
        wr_en   = w;
        wr      = '{addr: a, data: d};
        @(negedge sys_clk);
        clear   = 1'b0;
        restart = 1'b0;
        wr_en   = 1'b0;
        wr.data = ~wr.data;
    endtask : op
endmodule : vsg_host

// [dv/sync_gen_restart_reprogram_tb.sv]
`include "vsg_map.svh"
module sync_gen_restart_reprogram_tb;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin n_errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end

    logic             sys_clk = 1'b0;
    logic             arst_n  = 1'b0;
    logic             clear, restart, wr_en, h_drive, v_drive, first_frame;
    vsg_pkg::vsg_wr_t wr;
    logic [11:0]      h_count, v_count, status, hc, vc;
    logic [11:0]      m_reg [7];
    logic             hd, vd, ff;
    logic [31:0]      seed = 32'h5B49;
    int               n_errors = 0;
    int               n_tests = 0;

    always #2.5 sys_clk = ~sys_clk;

    vsg_host u_host (.sys_clk(sys_clk), .clear(clear), .restart(restart), .wr_en(wr_en),
                     .wr(wr));
    vsg_ctrl #(.CNT_W(12), .CEN_DEFAULT(1'b0)) DUT (.sys_clk(sys_clk), .arst_n(arst_n),
        .clear(clear), .restart(restart), .wr_en(wr_en), .wr(wr), .h_drive(h_drive),
        .v_drive(v_drive), .h_count(h_count), .v_count(v_count), .status(status),
        .first_frame(first_frame));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // ------------------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------------------
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n || clear) begin
            m_reg = '{`VSG_RST_STATUS, `VSG_RST_H_TOTAL, `VSG_RST_H_START, `VSG_RST_H_END,
                      `VSG_RST_V_TOTAL, `VSG_RST_V_START, `VSG_RST_V_END};
            hc = '0;
            vc = '0;
            ff = 1'b0;
            if (!arst_n) begin
                hd = 1'b0;
                vd = 1'b0;
            end
        end else begin
            if (restart) begin
                hc = '0;
                vc = '0;
                ff = 1'b1;
            end else if (m_reg[0][10]) begin
                hd = (ff || m_reg[2] <= hc) && hc < m_reg[3];
                vd = (ff || m_reg[5] <= vc) && vc < m_reg[6];
                if (hc == m_reg[1] || hc == 12'hFFF) begin
                    hc = '0;
                    if (vc == m_reg[4] || vc == 12'hFFF) begin
                        vc = '0;
                        ff = 1'b0;
                    end else vc++;
                end else hc++;
            end
            if (wr_en && wr.addr != 3'h7) m_reg[wr.addr] = wr.data;
        end
    end

    always @(negedge sys_clk) begin
        if (arst_n === 1'b1) begin
            `CHK("counts", {hc, vc}, {h_count, v_count})
            `CHK("drives", {hd, vd}, {h_drive, v_drive})
            `CHK("status", m_reg[0], status)
            `CHK("first_frame", ff, first_frame)
        end
    end

    task conclude();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    initial begin
        #200000;
        n_errors++;
        conclude();
    end

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    initial begin
        logic [11:0] cfg [6];
        logic [31:0] r;
        int          k;
        cfg = '{12'h00E, 12'h003, 12'h009, 12'h004, 12'h001, 12'h003};
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk) arst_n = 1'b1;
        u_host.op(1'b1, 1'b0, 1'b0, 3'h0, 12'h000);
        repeat (10) @(negedge sys_clk);
        `CHK("enable_default", 1'b0, status[10])
        `CHK("held_count", 12'h000, h_count)
        // loads while disabled must still land
        for (k = 0; k < 6; k++) u_host.op(1'b0, 1'b0, 1'b1, 3'(k + 1), cfg[k]);
        u_host.op(1'b0, 1'b0, 1'b1, 3'h0, 12'h400);
        repeat (300) @(negedge sys_clk);
        // move the end only once the line is past the new end, so no pulse is re-opened
        for (k = 0; k < 20 && h_count != 12'h00C; k++) @(negedge sys_clk);
        u_host.op(1'b0, 1'b0, 1'b1, 3'h3, 12'h00C);
        u_host.op(1'b0, 1'b1, 1'b0, 3'h7, 12'h000);
        `CHK("first_set", 1'b1, first_frame)
        repeat (200) @(negedge sys_clk);
        `CHK("first_done", 1'b0, first_frame)
        // lowering the total below the live count forces the long run to wrap
        u_host.op(1'b0, 1'b0, 1'b1, 3'h1, 12'h030);
        for (k = 0; k < 200 && h_count <= 12'h014; k++) @(negedge sys_clk);
        `CHK("overrun_start", 1'b1, h_count > 12'h014)
        u_host.op(1'b0, 1'b0, 1'b1, 3'h1, 12'h005);
        for (k = 0; k < 4200 && h_count != 12'hFFF; k++) @(negedge sys_clk);
        `CHK("overrun", 12'hFFF, h_count)
        u_host.op(1'b1, 1'b0, 1'b0, 3'h0, 12'h000);
        repeat (5) @(negedge sys_clk);
        `CHK("clear_status", 12'h000, status)
        `CHK("clear_count", 12'h000, h_count)
        for (int i = 0; i < 60; i++) begin
            r = rnd();
            if (r[6]) u_host.op(1'b0, 1'b0, 1'b1, 3'h0, 12'h000);
            repeat (3) begin
                r = rnd();
                u_host.op(1'b0, 1'b0, 1'b1, (r[10:8] == 3'h0) ? 3'h7 : r[10:8],
                          12'(r[4:0]) + 12'h002);
            end
            u_host.op(1'b0, 1'b1, 1'b0, 3'h7, 12'h000);
            u_host.op(1'b0, 1'b0, 1'b1, 3'h0, 12'h400);
            repeat (r[21:16]) @(negedge sys_clk);
        end
        conclude();
    end
endmodule : sync_gen_restart_reprogram_tb
